// file: rtl/keypad_backlight_pkg.sv
// constants, types and state record of the keypad and backlight controller
package keypad_backlight_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_PERIOD_NS = 1000000000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IDLE = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_CAL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CONTRAST = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_DISABLE_BIT = 1;
    localparam int THR_ON_LSB = 0;
    localparam int THR_OFF_LSB = 8;
    localparam int CAL_X_LSB = 0;
    localparam int CAL_Y_LSB = 16;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_BL_BIT = 3;
    localparam int STAT_CON_LSB = 8;
    localparam int STAT_LIGHT_BIT = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_IDLE = 16'h001E;
    localparam logic [7:0] RST_ON_LVL = 8'h40;
    localparam logic [7:0] RST_OFF_LVL = 8'h60;
    localparam logic [7:0] RST_CONTRAST = 8'h80;
    localparam logic [9:0] RST_CAL = 10'h000;

    // ------------------------------------------------------------
    // key codes
    // ------------------------------------------------------------
    localparam logic [6:0] KEY_SHIFT = 7'h63;
    localparam logic [6:0] KEY_DIGIT1 = 7'h02;
    localparam logic [6:0] KEY_DIGIT9 = 7'h0A;
    localparam logic [6:0] KEY_DIGIT0 = 7'h0B;
    localparam logic [6:0] FKEY_F1 = 7'h3B;
    localparam logic [6:0] FKEY_F10 = 7'h44;
    localparam logic [3:0] DIGIT_TOGGLE = 4'h7;
    localparam logic [3:0] DIGIT_UP = 4'h8;
    localparam logic [3:0] DIGIT_DOWN = 4'h9;
    localparam logic [7:0] CONTRAST_STEP = 8'h01;
    localparam logic [7:0] CONTRAST_MAX = 8'hFF;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BL_ON_MANUAL,
        BL_OFF_MANUAL,
        BL_ON_AUTO,
        BL_OFF_AUTO,
        BL_ON_OVERRIDE,
        BL_OFF_OVERRIDE
    } bl_state_t;

    typedef struct packed {
        bl_state_t blState;
        logic lightCond;
        logic [31:0] secCnt;
        logic [15:0] idleSec;
        logic [15:0] idleLim;
        logic idleFired;
        logic [7:0] onLvl;
        logic [7:0] offLvl;
        logic [7:0] contrast;
        logic shiftHeld;
        logic [9:0] mapped;
        logic [7:0] codeOut;
        logic codeValid;
        logic [9:0] calX;
        logic [9:0] calY;
        logic [9:0] ptrX;
        logic [9:0] ptrY;
        logic ptrIrq;
        logic [31:0] prdata;
    } state_t;

endpackage

// file: rtl/keypad_backlight_controller.sv
// keypad scan-code translation, backlight state machine and touch correction
`timescale 1ns/1ps

// Summary of operation
// (RQ1) send press and release codes per key, none for shift
// (RQ2) shift plus 1-6 gives F1-F6, 0 gives F10
// (RQ3) shift plus 7,8,9 emit no code
// (RQ4) shift plus 7 toggles the backlight
// (RQ5) shift plus 8/9 step contrast up/down
// (RQ6) idle period without input raises time-up
// (RQ7) automatic mode samples light once per second
// (RQ8) switch-on level kept below switch-off level
// (RQ9) backlight machine holds one of six states
// (RQ10) manual mode: toggle flips, time-up turns off
// (RQ11) automatic toggle: 3-6, 4-5, 5-4, 6-3
// (RQ12) enable from 1/2 picks 3 or 4
// (RQ13) disable from 3-6 goes to 2
// (RQ14) automatic: light 3-4, dark 4-3
// (RQ15) time-up ignored in states 3 and 4
// (RQ16) time-up in state 5 goes to 3
// (RQ17) dark in 5 to 3, light in 6 to 4
// (RQ18) correct touch coordinates, raise pointer interrupt
// (RQ19) unlisted events leave state unchanged
// (RQ20) reset enters state 2, idle timer cleared
module keypad_backlight_controller
    import keypad_backlight_pkg::*;
#(
    parameter int SEC_CYCLES = SAMPLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic keyValid,
    input wire logic keyUp,
    input wire logic [6:0] keyCode,
    output logic [7:0] scanCode,
    output logic scanValid,
    input wire logic [7:0] lightLevel,
    output logic backlightOn,
    output logic [7:0] contrast,
    input wire logic touchValid,
    input wire logic [9:0] touchX,
    input wire logic [9:0] touchY,
    output logic [9:0] pointerX,
    output logic [9:0] pointerY,
    output logic pointerIrq
);

    state_t s_q;
    state_t s_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] stateNumber(input bl_state_t st);
        logic [2:0] n;
        n = 3'h1;
        unique case (st)
            BL_ON_MANUAL: n = 3'h1;
            BL_OFF_MANUAL: n = 3'h2;
            BL_ON_AUTO: n = 3'h3;
            BL_OFF_AUTO: n = 3'h4;
            BL_ON_OVERRIDE: n = 3'h5;
            BL_OFF_OVERRIDE: n = 3'h6;
            default: n = 3'h0;
        endcase
        return n;
    endfunction

    function automatic logic [9:0] correct(input logic [9:0] raw, input logic [9:0] ofs);
        return (raw > ofs) ? raw - ofs : 10'h000;
    endfunction

    // ------------------------------------------------------------
    // decoded bus, key and timing events
    // ------------------------------------------------------------
    logic busWrite;
    logic busSetup;
    logic addrOk;
    logic isDigit;
    logic [3:0] digit;
    logic [6:0] fCode;
    logic activity;
    logic toggleEv;
    logic enableEv;
    logic disableEv;
    logic timeUpEv;
    logic darkEv;
    logic lightEv;
    logic tick;
    logic autoMode;
    logic newCond;

    assign busWrite = psel && penable && pwrite;
    assign busSetup = psel && !penable;
    assign addrOk = (paddr == OFS_CTRL) || (paddr == OFS_IDLE) || (paddr == OFS_THRESH)
        || (paddr == OFS_CAL) || (paddr == OFS_STATUS) || (paddr == OFS_CONTRAST);
    assign isDigit = (keyCode >= KEY_DIGIT1) && (keyCode <= KEY_DIGIT0);
    assign digit = (keyCode == KEY_DIGIT0) ? 4'h0 : 4'(keyCode - KEY_DIGIT1 + 7'h01);
    assign fCode = (digit == 4'h0) ? FKEY_F10 : FKEY_F1 + 7'(digit) - 7'h01;
    assign autoMode = (s_q.blState != BL_ON_MANUAL) && (s_q.blState != BL_OFF_MANUAL);
    assign tick = (s_q.secCnt == 32'(SEC_CYCLES - 1));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.codeValid = 1'b0;
        s_d.ptrIrq = 1'b0;
        activity = 1'b0;
        toggleEv = 1'b0;
        enableEv = 1'b0;
        disableEv = 1'b0;
        timeUpEv = 1'b0;
        darkEv = 1'b0;
        lightEv = 1'b0;
        newCond = s_q.lightCond;

        // ------------------------------------------------------------
        // register bus
        // ------------------------------------------------------------
        if (busSetup) begin
            s_d.prdata = 32'h0000_0000;
            unique case (paddr)
                OFS_IDLE: s_d.prdata[15:0] = s_q.idleLim;
                OFS_THRESH: begin
                    s_d.prdata[THR_ON_LSB +: 8] = s_q.onLvl;
                    s_d.prdata[THR_OFF_LSB +: 8] = s_q.offLvl;
                end
                OFS_CAL: begin
                    s_d.prdata[CAL_X_LSB +: 10] = s_q.calX;
                    s_d.prdata[CAL_Y_LSB +: 10] = s_q.calY;
                end
                OFS_STATUS: begin
                    s_d.prdata[STAT_STATE_LSB +: 3] = stateNumber(s_q.blState);
                    s_d.prdata[STAT_BL_BIT] = backlightOn;
                    s_d.prdata[STAT_CON_LSB +: 8] = s_q.contrast;
                    s_d.prdata[STAT_LIGHT_BIT] = s_q.lightCond;
                end
                OFS_CONTRAST: s_d.prdata[7:0] = s_q.contrast;
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end
        if (busWrite) begin
            unique case (paddr)
                OFS_CTRL: begin
                    enableEv = pwdata[CTRL_ENABLE_BIT];
                    disableEv = pwdata[CTRL_DISABLE_BIT];
                end
                OFS_IDLE: s_d.idleLim = pwdata[15:0];
                OFS_THRESH: begin
                    if (pwdata[THR_ON_LSB +: 8] < pwdata[THR_OFF_LSB +: 8]) begin // RQ8
                        s_d.onLvl = pwdata[THR_ON_LSB +: 8];
                        s_d.offLvl = pwdata[THR_OFF_LSB +: 8];
                    end
                end
                OFS_CAL: begin
                    s_d.calX = pwdata[CAL_X_LSB +: 10];
                    s_d.calY = pwdata[CAL_Y_LSB +: 10];
                end
                OFS_CONTRAST: s_d.contrast = pwdata[7:0];
                default: s_d.calX = s_q.calX;
            endcase
        end

        // ------------------------------------------------------------
        // keys
        // ------------------------------------------------------------
        if (keyValid) begin
            activity = 1'b1;
            if (keyCode == KEY_SHIFT) begin
                s_d.shiftHeld = !keyUp;
            end else if (isDigit && !keyUp && s_q.shiftHeld) begin
                s_d.mapped[digit] = 1'b1;
                unique case (digit)
                    DIGIT_TOGGLE: toggleEv = 1'b1; // RQ3 RQ4
                    DIGIT_UP: begin
                        if (s_q.contrast != CONTRAST_MAX) begin
                            s_d.contrast = s_q.contrast + CONTRAST_STEP; // RQ5
                        end
                    end
                    DIGIT_DOWN: begin
                        if (s_q.contrast != 8'h00) begin
                            s_d.contrast = s_q.contrast - CONTRAST_STEP; // RQ5
                        end
                    end
                    default: begin
                        s_d.codeOut = {1'b0, fCode}; // RQ2
                        s_d.codeValid = 1'b1;
                    end
                endcase
            end else if (isDigit && keyUp && s_q.mapped[digit]) begin
                s_d.mapped[digit] = 1'b0;
                if (digit < DIGIT_TOGGLE) begin
                    s_d.codeOut = {1'b1, fCode}; // RQ2
                    s_d.codeValid = 1'b1;
                end
            end else begin
                s_d.codeOut = {keyUp, keyCode}; // RQ1
                s_d.codeValid = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // touch
        // ------------------------------------------------------------
        if (touchValid) begin
            activity = 1'b1;
            s_d.ptrX = correct(touchX, s_q.calX); // RQ18
            s_d.ptrY = correct(touchY, s_q.calY); // RQ18
            s_d.ptrIrq = 1'b1; // RQ18
        end

        // ------------------------------------------------------------
        // one-second time base and ambient sampling
        // ------------------------------------------------------------
        s_d.secCnt = tick ? 32'h0000_0000 : s_q.secCnt + 32'h0000_0001;
        if (tick && autoMode) begin
            if (lightLevel < s_q.onLvl) begin // RQ7
                newCond = 1'b0;
            end else if (lightLevel > s_q.offLvl) begin
                newCond = 1'b1;
            end
            darkEv = s_q.lightCond && !newCond;
            lightEv = !s_q.lightCond && newCond;
            s_d.lightCond = newCond;
        end

        // ------------------------------------------------------------
        // idle timer
        // ------------------------------------------------------------
        if (activity) begin
            s_d.idleSec = 16'h0000;
            s_d.idleFired = 1'b0;
        end else if (tick && (s_q.idleLim != 16'h0000) && !s_q.idleFired) begin
            if (s_q.idleSec + 16'h0001 >= s_q.idleLim) begin
                timeUpEv = 1'b1; // RQ6
                s_d.idleFired = 1'b1;
            end else begin
                s_d.idleSec = s_q.idleSec + 16'h0001;
            end
        end

        // ------------------------------------------------------------
        // backlight machine: disable, enable, toggle, time-up, light change
        // ------------------------------------------------------------
        if (disableEv && autoMode) begin
            s_d.blState = BL_OFF_MANUAL; // RQ13
        end else if (enableEv && !autoMode) begin
            s_d.lightCond = !(lightLevel < s_q.onLvl);
            s_d.blState = (lightLevel < s_q.onLvl) ? BL_ON_AUTO : BL_OFF_AUTO; // RQ12
        end else begin
            unique case (s_q.blState) // RQ9 RQ19
                BL_ON_MANUAL: begin
                    if (toggleEv || timeUpEv) begin
                        s_d.blState = BL_OFF_MANUAL; // RQ10
                    end
                end
                BL_OFF_MANUAL: begin
                    if (toggleEv) begin
                        s_d.blState = BL_ON_MANUAL; // RQ10
                    end
                end
                BL_ON_AUTO: begin
                    if (toggleEv) begin
                        s_d.blState = BL_OFF_OVERRIDE; // RQ11
                    end else if (lightEv) begin
                        s_d.blState = BL_OFF_AUTO; // RQ14 RQ15
                    end
                end
                BL_OFF_AUTO: begin
                    if (toggleEv) begin
                        s_d.blState = BL_ON_OVERRIDE; // RQ11
                    end else if (darkEv) begin
                        s_d.blState = BL_ON_AUTO; // RQ14 RQ15
                    end
                end
                BL_ON_OVERRIDE: begin
                    if (toggleEv) begin
                        s_d.blState = BL_OFF_AUTO; // RQ11
                    end else if (timeUpEv) begin
                        s_d.blState = BL_ON_AUTO; // RQ16
                    end else if (darkEv) begin
                        s_d.blState = BL_ON_AUTO; // RQ17
                    end
                end
                BL_OFF_OVERRIDE: begin
                    if (toggleEv) begin
                        s_d.blState = BL_ON_AUTO; // RQ11
                    end else if (lightEv) begin
                        s_d.blState = BL_OFF_AUTO; // RQ17
                    end
                end
                default: begin
                    s_d.blState = BL_OFF_MANUAL;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.blState <= BL_OFF_MANUAL; // RQ20
            s_q.lightCond <= 1'b1;
            s_q.idleLim <= RST_IDLE;
            s_q.onLvl <= RST_ON_LVL;
            s_q.offLvl <= RST_OFF_LVL;
            s_q.contrast <= RST_CONTRAST;
            s_q.calX <= RST_CAL;
            s_q.calY <= RST_CAL;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign backlightOn = (s_q.blState == BL_ON_MANUAL) || (s_q.blState == BL_ON_AUTO)
        || (s_q.blState == BL_ON_OVERRIDE);
    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrOk;
    assign scanCode = s_q.codeOut;
    assign scanValid = s_q.codeValid;
    assign contrast = s_q.contrast;
    assign pointerX = s_q.ptrX;
    assign pointerY = s_q.ptrY;
    assign pointerIrq = s_q.ptrIrq;

endmodule

// file: sim/keypad_backlight_checker.sv
// port assertions for the keypad and backlight controller
`timescale 1ns/1ps
module keypad_backlight_checker
    import keypad_backlight_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic keyValid,
    input wire logic keyUp,
    input wire logic [6:0] keyCode,
    input wire logic [7:0] scanCode,
    input wire logic scanValid,
    input wire logic [7:0] contrast,
    input wire logic touchValid,
    input wire logic [9:0] pointerX,
    input wire logic [9:0] pointerY,
    input wire logic pointerIrq
);
    logic shiftQ;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shiftQ <= 1'b0;
        end else if (keyValid && keyCode == KEY_SHIFT) begin
            shiftQ <= !keyUp;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence sFnPress(c);
        shiftQ && keyValid && !keyUp && keyCode == c;
    endsequence
    sequence sPlainKey;
        keyValid && keyCode > KEY_DIGIT0 && keyCode != KEY_SHIFT;
    endsequence
    property pStep(c, lim, up);
        sFnPress(c) |=> contrast == (($past(contrast) == lim) ? lim
            : up ? $past(contrast) + CONTRAST_STEP : $past(contrast) - CONTRAST_STEP);
    endproperty
    a_scan_plain: assert property (sPlainKey |=> scanValid && scanCode == {$past(keyUp), $past(keyCode)})
        else $error("plain key gave wrong code");
    a_scan_cause: assert property (scanValid |-> $past(keyValid))
        else $error("code without key event");
    a_fkey_map: assert property (shiftQ && keyValid && !keyUp && keyCode inside {[7'h02:7'h07]}
        |=> scanValid && scanCode == {1'b0, $past(keyCode) + FKEY_F1 - KEY_DIGIT1})
        else $error("shifted digit gave wrong code");
    a_fkey_ten: assert property (sFnPress(KEY_DIGIT0) |=> scanValid && scanCode == {1'b0, FKEY_F10})
        else $error("shifted zero gave wrong code");
    a_fn_silent: assert property (shiftQ && keyValid && !keyUp && keyCode inside {[7'h08:7'h0A]}
        |=> !scanValid)
        else $error("internal key emitted a code");
    a_contrast_up: assert property (pStep(7'h09, CONTRAST_MAX, 1'b1))
        else $error("contrast did not step up");
    a_contrast_down: assert property (pStep(KEY_DIGIT9, 8'h00, 1'b0))
        else $error("contrast did not step down");
    a_contrast_hold: assert property (!keyValid && !(psel && penable && pwrite) |=> $stable(contrast))
        else $error("contrast moved without cause");
    a_irq_touch: assert property (touchValid |=> pointerIrq)
        else $error("no pointer interrupt after touch");
    a_irq_cause: assert property (pointerIrq |-> $past(touchValid))
        else $error("pointer interrupt without touch");
    a_pointer_hold: assert property (!touchValid |=> $stable(pointerX) && $stable(pointerY))
        else $error("pointer moved without touch");
endmodule
bind keypad_backlight_controller keypad_backlight_checker chk (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .keyValid(keyValid), .keyUp(keyUp),
    .keyCode(keyCode), .scanCode(scanCode), .scanValid(scanValid), .contrast(contrast),
    .touchValid(touchValid), .pointerX(pointerX), .pointerY(pointerY), .pointerIrq(pointerIrq));

// file: sim/host_cpu_model.sv
// main processor model collecting scan codes and pointer data
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic clock,
    input wire logic scanValid,
    input wire logic [7:0] scanCode,
    input wire logic pointerIrq,
    input wire logic [9:0] pointerX,
    input wire logic [9:0] pointerY
);
    logic [7:0] codes[$];
    logic [9:0] px = 10'h000;
    logic [9:0] py = 10'h000;
    int irqs = 0;
    always @(posedge clock) begin
        if (scanValid === 1'b1) begin
            codes.push_back(scanCode);
        end
        if (pointerIrq === 1'b1) begin
            px <= pointerX;
            py <= pointerY;
            irqs <= irqs + 1;
        end
    end
endmodule

// file: sim/keypad_backlight_controller_test.sv
// self-checking bench for the keypad and backlight controller
`timescale 1ns/1ps
module keypad_backlight_controller_test
    import keypad_backlight_pkg::*;
;
    localparam int SEC = 20;
    localparam logic [31:0] NONE = 32'h100;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic keyValid, keyUp, scanValid, backlightOn, touchValid, pointerIrq;
    logic [7:0] paddr, scanCode, lightLevel, contrast;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] keyCode, c, e;
    logic [9:0] touchX, touchY, pointerX, pointerY, ox, oy;
    int badCount = 0;
    int cmpCount = 0;
    int seen = 0;
    int irqBase = 0;
    string plan = "T1T2T1I2D2E3E3T6L4I4T5I3D3L4D3T6T3L4T5D3T6X2L2E4T5T4X2";
    keypad_backlight_controller #(.SEC_CYCLES(SEC)) dut (.clock(clock), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .keyValid(keyValid),
        .keyUp(keyUp), .keyCode(keyCode), .scanCode(scanCode), .scanValid(scanValid),
        .lightLevel(lightLevel), .backlightOn(backlightOn), .contrast(contrast),
        .touchValid(touchValid), .touchX(touchX), .touchY(touchY), .pointerX(pointerX),
        .pointerY(pointerY), .pointerIrq(pointerIrq));
    host_cpu_model cpu (.clock(clock), .scanValid(scanValid), .scanCode(scanCode),
        .pointerIrq(pointerIrq), .pointerX(pointerX), .pointerY(pointerY));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task st(input int s);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, s[0], 3'(s)});
        chk({31'h0, backlightOn}, {31'h0, s[0]});
    endtask
    task key(input logic up, input logic [6:0] k, input logic [31:0] exp);
        keyValid <= 1'b1;
        keyUp <= up;
        keyCode <= k;
        @(posedge clock);
        keyValid <= 1'b0;
        repeat (2) @(posedge clock);
        chk(cpu.codes.size() == seen ? NONE : {24'h0, cpu.codes[seen]}, exp);
        seen = cpu.codes.size();
    endtask
    task sec(input logic [31:0] idle, input logic [7:0] lvl, input int n);
        apb(1'b1, OFS_IDLE, idle);
        lightLevel <= lvl;
        repeat (n * SEC) @(posedge clock);
        apb(1'b1, OFS_IDLE, 32'h0);
    endtask
    task act(input byte a);
        case (a)
            "T": begin
                key(1'b0, 7'h08, NONE);
                key(1'b1, 7'h08, NONE);
            end
            "L": sec(32'h0, 8'h70, 2);
            "D": sec(32'h0, 8'h10, 2);
            "I": sec(32'h1, lightLevel, 3);
            "E": apb(1'b1, OFS_CTRL, 32'h1);
            default: apb(1'b1, OFS_CTRL, 32'h2);
        endcase
    endtask
    function automatic logic [9:0] corr(input logic [9:0] raw, input logic [9:0] off);
        return raw > off ? raw - off : 10'h000;
    endfunction
    task finalReport;
        if (badCount == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (30000) @(posedge clock);
        badCount++;
        finalReport;
    end
    initial begin
        {rst_n, psel, penable, pwrite, keyValid, keyUp, touchValid} = 7'h0;
        {paddr, pwdata, keyCode, touchX, touchY} = 67'h0;
        lightLevel = 8'h50;
        void'($urandom(11));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0001_8002);
        apb(1'b1, OFS_THRESH, 32'h0000_5070);
        apb(1'b0, OFS_THRESH, 32'h0);
        chk(rd, 32'h0000_6040);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            c = 7'h10 + 7'($urandom % 32);
            key(1'b0, c, {25'h0, c});
            key(1'b1, c, {24'h0, 1'b1, c});
        end
        key(1'b0, KEY_SHIFT, NONE);
        for (int d = 0; d < 7; d++) begin
            c = d == 0 ? KEY_DIGIT0 : KEY_DIGIT1 + 7'(d - 1);
            e = d == 0 ? FKEY_F10 : FKEY_F1 + 7'(d - 1);
            key(1'b0, c, {25'h0, e});
            key(1'b1, c, {24'h0, 1'b1, e});
        end
        key(1'b0, 7'h09, NONE);
        chk({24'h0, contrast}, 32'h81);
        repeat (2) key(1'b0, KEY_DIGIT9, NONE);
        chk({24'h0, contrast}, 32'h7F);
        apb(1'b1, OFS_CONTRAST, 32'h0000_00FF);
        key(1'b0, 7'h09, NONE);
        apb(1'b0, OFS_CONTRAST, 32'h0);
        chk(rd, 32'h0000_00FF);
        apb(1'b1, OFS_CONTRAST, 32'h0000_0001);
        repeat (2) key(1'b0, KEY_DIGIT9, NONE);
        chk({24'h0, contrast}, 32'h0);
        apb(1'b0, OFS_IDLE, 32'h0);
        chk(rd, {16'h0, RST_IDLE});
        for (int i = 0; i < plan.len(); i += 2) begin
            act(plan[i]);
            st(int'(plan[i + 1]) - 48);
        end
        ox = 10'($urandom % 64);
        oy = 10'($urandom % 64);
        apb(1'b1, OFS_CAL, {6'h0, oy, 6'h0, ox});
        for (int i = 0; i < 4; i++) begin
            touchX <= 10'($urandom % 128);
            touchY <= 10'($urandom % 128);
            irqBase = cpu.irqs;
            touchValid <= 1'b1;
            @(posedge clock);
            touchValid <= 1'b0;
            repeat (2) @(posedge clock);
            chk(cpu.irqs - irqBase, 32'h1);
            chk({cpu.py, cpu.px}, {corr(touchY, oy), corr(touchX, ox)});
        end
        key(1'b1, KEY_SHIFT, NONE);
        finalReport;
    end
endmodule
